/* verilog/sscc_pkg.sv */
package sscc_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 18;
    localparam int BYTE_N = 2;

    // ****************************************
    // strap encoding for burst order
    // ****************************************
    localparam logic BURST_LINEAR      = 1'b0;
    localparam logic BURST_INTERLEAVED = 1'b1;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int POWER_WAIT_US  = 1000;
    // least time, rounded up to whole cycles
    localparam int POWER_WAIT_CYC =
        (POWER_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] BURST_CNT_RST = 2'h0;

endpackage : sscc_pkg

/* verilog/sscc_burst_addr.sv */
// ****************************************
// burst address generator
// ****************************************
module sscc_burst_addr (
    // base address and count
    input  wire logic [sscc_pkg::ADDR_W-1:0] base_i,
    input  wire logic [1:0]                  count_i,
    // order strap
    input  wire logic                        mode_i,
    // generated address
    output logic      [sscc_pkg::ADDR_W-1:0] addr_o
);

    // low two bits: add for linear, xor for interleaved
    function automatic logic [1:0] sscc_next_low(input logic [1:0] low,
                                                 input logic [1:0] cnt,
                                                 input logic       mode);
        if (mode == sscc_pkg::BURST_INTERLEAVED) begin
            sscc_next_low = low ^ cnt;
        end else begin
            sscc_next_low = low + cnt;
        end
    endfunction : sscc_next_low

    // upper bits never change within a burst
    always_comb begin
        addr_o = {base_i[sscc_pkg::ADDR_W-1:2], sscc_next_low(base_i[1:0], count_i, mode_i)};
    end

endmodule : sscc_burst_addr

/* verilog/sscc_core.sv */
// Function
// - The device is selected only with first select low, second high and third low.
// - Burst addresses run in linear order with strap 0 and interleaved order with strap 1.
// - A clock edge with the clock qualifier deasserted is a stall: no write, op and bus held unless a sleep request drops them.
// - Data outputs stay high impedance on leaving sleep until a new read enables them.
module sscc_core (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    // pins from the controller
    input  wire logic                        clock_qualifier_n_i,
    input  wire logic                        chip_select_first_n_i,
    input  wire logic                        chip_select_second_i,
    input  wire logic                        chip_select_third_n_i,
    input  wire logic                        sleep_request_i,
    input  wire logic                        burst_mode_i,
    input  wire logic                        adv_load_i,
    input  wire logic                        write_n_i,
    input  wire logic [sscc_pkg::BYTE_N-1:0] byte_write_n_i,
    input  wire logic [sscc_pkg::ADDR_W-1:0] addr_i,
    // data bus, split into three signals
    input  wire logic [sscc_pkg::DATA_W-1:0] data_i,
    output logic      [sscc_pkg::DATA_W-1:0] data_o,
    output logic                             data_oe_o,
    // array side
    output logic                             mem_we_o,
    output logic      [sscc_pkg::BYTE_N-1:0] mem_be_o,
    output logic      [sscc_pkg::ADDR_W-1:0] mem_addr_o,
    output logic      [sscc_pkg::DATA_W-1:0] mem_wdata_o,
    input  wire logic [sscc_pkg::DATA_W-1:0] mem_rdata_i,
    // status
    output logic                             sleeping_o,
    output logic                             power_ready_o
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {SSCC_IDLE, SSCC_READ, SSCC_WRITE} sscc_op_t;

    typedef struct packed {
        logic                        s1_q;      // sleep sync stage one
        logic                        s2_q;      // sleep sync stage two
        sscc_op_t                    op;
        logic [sscc_pkg::ADDR_W-1:0] base;
        logic [1:0]                  cnt;
        logic [sscc_pkg::BYTE_N-1:0] be;
        logic                        strap;
        logic                        oe;
        logic [sscc_pkg::DATA_W-1:0] dout;
        logic                        sleep;
        logic [19:0]                 pwr_cnt;
        logic                        pwr_ok;
    } sscc_state_t;

    sscc_state_t st;
    sscc_state_t next_st;

    logic                        qual_n;
    logic                        sleep_req;
    logic                        selected;
    logic [sscc_pkg::ADDR_W-1:0] burst_addr;

    // ****************************************
    // select decode
    // ****************************************
    function automatic logic sscc_selected(input logic f_n, input logic s, input logic t_n);
        sscc_selected = !f_n && s && !t_n;
    endfunction : sscc_selected

    // qualifier comes from the controller's own clock: a synchroniser would
    // move the stall two edges away from the edge it is meant to cancel
    assign qual_n    = clock_qualifier_n_i;
    // sleep pin is asynchronous, so it alone is synchronised
    assign sleep_req = st.s2_q;
    // pins are registered in the device, so decode is direct
    assign selected  = sscc_selected(chip_select_first_n_i, chip_select_second_i,
                                     chip_select_third_n_i);

    sscc_burst_addr u_burst (
        .base_i  (st.base),
        .count_i (st.cnt),
        .mode_i  (st.strap),
        .addr_o  (burst_addr)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st      = st;
        next_st.s1_q = sleep_request_i;
        next_st.s2_q = st.s1_q;
        next_st.sleep = sleep_req;
        // strap taken only while idle, treated as static
        if (st.op == SSCC_IDLE) begin
            next_st.strap = burst_mode_i;
        end
        if (!st.pwr_ok) begin
            if (st.pwr_cnt == 20'(sscc_pkg::POWER_WAIT_CYC - 1)) begin
                next_st.pwr_ok = 1'b1;
            end else begin
                next_st.pwr_cnt = st.pwr_cnt + 20'h00001;
            end
        end
        if (sleep_req) begin
            // sleep: drop the pending op and float the bus
            next_st.op = SSCC_IDLE;
            next_st.oe = 1'b0;
        end else if (!qual_n) begin
            // stalled edges skip this branch, holding op and data
            if (selected && !adv_load_i) begin
                // new access with fresh address
                next_st.base = addr_i;
                next_st.cnt  = sscc_pkg::BURST_CNT_RST;
                next_st.be   = ~byte_write_n_i;
                next_st.op   = write_n_i ? SSCC_READ : SSCC_WRITE;
            end else if (adv_load_i && st.op != SSCC_IDLE) begin
                next_st.cnt = st.cnt + 2'h1;
            end else begin
                next_st.op = SSCC_IDLE; // deselect or nop
            end
            // drive the bus the cycle after a read edge, in step with its data
            case (st.op)
                SSCC_READ:  next_st.oe = 1'b1;
                SSCC_WRITE: next_st.oe = 1'b0;
                SSCC_IDLE:  next_st.oe = 1'b0;
                default:    next_st.oe = 1'b0;
            endcase
        end
        if (st.op == SSCC_READ && !qual_n && !sleep_req) begin
            next_st.dout = mem_rdata_i;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // write only on a live, awake edge
    assign mem_we_o      = ce_i && st.op == SSCC_WRITE && !qual_n && !sleep_req;
    assign mem_be_o      = st.be;
    assign mem_addr_o    = burst_addr;
    assign mem_wdata_o   = data_i;
    assign data_o        = st.dout;
    assign data_oe_o     = st.oe;
    assign sleeping_o    = st.sleep;
    assign power_ready_o = st.pwr_ok;

    // ****************************************
    // checks
    // ****************************************
    property p_no_write_stall;
        @(posedge clk_i) disable iff (rst_i) qual_n |-> !mem_we_o;
    endproperty
    a_no_write_stall: assert property (p_no_write_stall)
        else $error("write during stall");

    property p_stall_holds;
        @(posedge clk_i) disable iff (rst_i) (ce_i && qual_n && !sleep_req)
            |=> (st.op == $past(st.op) && st.cnt == $past(st.cnt));
    endproperty
    a_stall_holds: assert property (p_stall_holds)
        else $error("stall changed op state");

    property p_sleep_float;
        @(posedge clk_i) disable iff (rst_i) (ce_i && sleep_req) |=> !data_oe_o;
    endproperty
    a_sleep_float: assert property (p_sleep_float)
        else $error("bus driven in sleep");

    property p_sleep_idle;
        @(posedge clk_i) disable iff (rst_i) (ce_i && sleep_req) |=> st.op == SSCC_IDLE;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle)
        else $error("access taken in sleep");

    property p_deselect;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && !qual_n && !sleep_req && !selected && !adv_load_i)
            |=> st.op == SSCC_IDLE;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("deselected access started");

    property p_linear;
        @(posedge clk_i) disable iff (rst_i) (st.strap == sscc_pkg::BURST_LINEAR)
            |-> mem_addr_o[1:0] == 2'(st.base[1:0] + st.cnt);
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear order wrong");

    property p_interleave;
        @(posedge clk_i) disable iff (rst_i) (st.strap == sscc_pkg::BURST_INTERLEAVED)
            |-> mem_addr_o[1:0] == (st.base[1:0] ^ st.cnt);
    endproperty
    a_interleave: assert property (p_interleave)
        else $error("interleaved order wrong");

    property p_fresh_addr;
        @(posedge clk_i) disable iff (rst_i)
            (ce_i && !qual_n && !sleep_req && selected && !adv_load_i)
            |=> (st.base == $past(addr_i) && st.cnt == 2'h0);
    endproperty
    a_fresh_addr: assert property (p_fresh_addr)
        else $error("single access address not taken");

    c_read:  cover property (@(posedge clk_i) disable iff (rst_i) st.op == SSCC_READ ##1 data_oe_o);
    c_write: cover property (@(posedge clk_i) disable iff (rst_i) mem_we_o);
    c_stall: cover property (@(posedge clk_i) disable iff (rst_i) st.op != SSCC_IDLE && qual_n);
    c_sleep: cover property (@(posedge clk_i) disable iff (rst_i) sleeping_o ##1 !sleeping_o);

endmodule : sscc_core

/* test/sscc_ctrl_model.sv */
// ****************************************
// controller model on the device pins
// ****************************************
module sscc_ctrl_model (
    // clock
    input  wire logic                        clk_i,
    // pins toward the device
    output logic                             qual_n_o,
    output logic      [2:0]                  sel_o,
    output logic                             sleep_o,
    output logic                             adv_o,
    output logic                             wr_n_o,
    output logic      [sscc_pkg::BYTE_N-1:0] be_n_o,
    output logic      [sscc_pkg::ADDR_W-1:0] addr_o,
    output logic      [sscc_pkg::DATA_W-1:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic                        pend;
    logic [sscc_pkg::DATA_W-1:0] pend_d;

    // idle pins at time zero: deselected, live clock
    initial begin
        {qual_n_o, sleep_o, adv_o, pend, addr_o, data_o, pend_d} = '0;
        {sel_o, wr_n_o, be_n_o} = 6'h3F;
    end

    // one cycle; write data trails its address by one cycle
    task automatic cycle(input logic [2:0] s, input logic a, input logic w, input logic [1:0] b,
                         input logic [16:0] ad, input logic [17:0] d);
        @(negedge clk_i);
        {sel_o, adv_o, wr_n_o, be_n_o, addr_o} = {s, a, w, b, ad};
        data_o = pend ? pend_d : ~data_o; // released bus never shows a stale value
        pend = !w && !a;
        pend_d = d;
        // let the pins settle before the bench looks at the outputs
        #1;
    endtask : cycle

    // deselect first, then change the sleep request
    task automatic nap(input logic on);
        cycle(3'h7, 1'b0, 1'b1, 2'h3, addr_o, '0);
        @(negedge clk_i);
        sleep_o = on;
    endtask : nap

    // clock qualifier level
    task automatic stall(input logic on);
        @(negedge clk_i);
        qual_n_o = on;
        #1;
    endtask : stall
endmodule : sscc_ctrl_model

/* test/sync_sram_cycle_control_tb.sv */
module sync_sram_cycle_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        mode  = 1'b0;
    logic        ce    = 1'b1;
    logic        qn, slp, adv, wn, oe, we, slpg, prdy;
    logic [2:0]  sel;
    logic [1:0]  ben, be;
    logic [16:0] ad, ma, a;
    logic [17:0] wd, rd, mwd, mrd, d;
    int          errors = 0;
    int          n_tests = 0;
    int          seed = 32'h7203c590;

    always #4 clk_i = ~clk_i;
    // array read data is a fixed pattern of the address
    assign mrd = {1'b1, ma} ^ 18'h2A5A5;

    sscc_ctrl_model sscc_ctrl_model_inst (.clk_i(clk_i), .qual_n_o(qn), .sel_o(sel),
        .sleep_o(slp), .adv_o(adv), .wr_n_o(wn), .be_n_o(ben), .addr_o(ad), .data_o(wd));
    sscc_core sscc_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .clock_qualifier_n_i(qn), .chip_select_first_n_i(sel[2]),
        .chip_select_second_i(sel[1]), .chip_select_third_n_i(sel[0]),
        .sleep_request_i(slp), .burst_mode_i(mode), .adv_load_i(adv), .write_n_i(wn),
        .byte_write_n_i(ben), .addr_i(ad), .data_i(wd), .data_o(rd), .data_oe_o(oe),
        .mem_we_o(we), .mem_be_o(be), .mem_addr_o(ma), .mem_wdata_o(mwd),
        .mem_rdata_i(mrd), .sleeping_o(slpg), .power_ready_o(prdy));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic nop(input int n);
        repeat (n) sscc_ctrl_model_inst.cycle(3'h7, 1'b0, 1'b1, 2'h3, 17'h0, 18'h0);
    endtask : nop

    function automatic logic [16:0] burst(input logic [16:0] b, input logic [1:0] k,
                                          input logic m);
        return {b[16:2], m ? b[1:0] ^ k : b[1:0] + k};
    endfunction : burst

    task automatic rd_chk(input logic [16:0] x);
        sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b1, 2'h3, x, 18'h0);
        nop(1);
        check("raddr", x, ma);
        nop(1);
        check("rdata", {1'b1, x} ^ 18'h2A5A5, rd);
        check("oe", 1, oe);
    endtask : rd_chk

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        nop(3);
        // every select combination; only 0/1/0 may write
        for (int s = 0; s < 8; s++) begin
            sscc_ctrl_model_inst.cycle(s[2:0], 1'b0, 1'b0, 2'h0, 17'h100 + s, 18'h155);
            nop(1);
            check("we", s == 2, we);
        end
        $display("decode done");
        // random single writes and reads at fresh addresses
        repeat (16) begin
            a = $random(seed);
            d = $random(seed);
            sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b0, d[1:0], a, d);
            nop(1);
            check("we", 1, we);
            check("waddr", a, ma);
            check("be", 2'(~d[1:0]), be);
            check("wdata", d, mwd);
            rd_chk(a);
        end
        $display("single done");
        // both burst orders from a base near the wrap
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            nop(2);
            a = $random(seed) | 1;
            sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b1, 2'h3, a, 18'h0);
            for (int k = 0; k < 4; k++) begin
                sscc_ctrl_model_inst.cycle(3'h2, 1'b1, 1'b1, 2'h3, a, 18'h0);
                check("baddr", burst(a, k[1:0], m[0]), ma);
            end
            nop(2);
        end
        $display("burst done");
        // a write pending across stalled edges lands on the next live edge
        sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b0, 2'h0, 17'h55, 18'h2AA);
        sscc_ctrl_model_inst.stall(1'b1);
        check("we", 0, we);
        nop(1);
        check("we", 0, we);
        sscc_ctrl_model_inst.stall(1'b0);
        check("we", 1, we);
        check("waddr", 17'h55, ma);
        check("wdata", 18'h2AA, mwd);
        // a load on a stalled edge is dropped
        sscc_ctrl_model_inst.stall(1'b1);
        sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b0, 2'h0, 17'h56, 18'h2AB);
        for (int i = 0; i < 3; i++) begin
            nop(1);
            check("we", 0, we);
        end
        sscc_ctrl_model_inst.stall(1'b0);
        check("we", 0, we);
        // clock enable low freezes a pending write and blocks its strobe
        sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b0, 2'h0, 17'h66, 18'h133);
        nop(1);
        ce = 1'b0;
        #1;
        check("we", 0, we);
        nop(1);
        check("we", 0, we);
        ce = 1'b1;
        #1;
        check("we", 1, we);
        check("waddr", 17'h66, ma);
        nop(1);
        $display("stall done");
        // sleep entry during a stall, bus already released by the live edge before it, ignored access, exit
        rd_chk(17'h1F0F0);
        sscc_ctrl_model_inst.stall(1'b1);
        sscc_ctrl_model_inst.nap(1'b1);
        nop(3);
        check("sleeping", 1, slpg);
        check("oe", 0, oe);
        sscc_ctrl_model_inst.stall(1'b0);
        sscc_ctrl_model_inst.cycle(3'h2, 1'b0, 1'b0, 2'h0, 17'h77, 18'h3);
        nop(1);
        check("we", 0, we);
        check("sleep addr", 17'h1F0F0, ma);
        sscc_ctrl_model_inst.nap(1'b0);
        nop(3);
        check("sleeping", 0, slpg);
        check("oe", 0, oe);
        rd_chk(17'h0ABC);
        // run is far shorter than the power wait, so the flag stays low
        check("ready", 0, prdy);
        $display("sleep done");
        // mid-run reset: bus released and power wait restarted
        rst_i = 1'b1;
        nop(2);
        check("oe", 0, oe);
        check("ready", 0, prdy);
        rst_i = 1'b0;
        nop(2);
        rd_chk(17'h1357);
        $display("reset done");
        print_verdict();
    end
endmodule : sync_sram_cycle_control_tb
